//--- rtl/hpmux_map.vh
`ifndef HPMUX_MAP_VH
`define HPMUX_MAP_VH
// register offsets
`define HPMUX_OFS_MODE 4'h0
`define HPMUX_OFS_GPIO_OUT 4'h1
`define HPMUX_OFS_GPIO_OE 4'h2
`define HPMUX_OFS_GPIO_IN 4'h3
`define HPMUX_OFS_CAPTURE 4'h4
`define HPMUX_OFS_STATUS 4'h5
// mode register fields
`define HPMUX_MODE_W 2
`define HPMUX_MODE_GPIO 2'h0
`define HPMUX_MODE_PRIMARY 2'h1
`define HPMUX_MODE_SERIAL 2'h2
`define HPMUX_MODE_ROM 2'h3
`define HPMUX_MODE_RGB_BIT 2
// capture register field
`define HPMUX_CAP_RGB_BIT 0
// pin indices of the nine shared pins
`define HPMUX_PIN_CFG 0
`define HPMUX_PIN_CS 1
`define HPMUX_PIN_CK 2
`define HPMUX_PIN_DO 3
`define HPMUX_PIN_DI 4
`define HPMUX_PIN_BD 5
`define HPMUX_PIN_TD 6
`define HPMUX_PIN_BG 7
`define HPMUX_PIN_SW 8
`define HPMUX_NPINS 9
// reset values
`define HPMUX_RST_MODE 3'h0
`define HPMUX_RST_GPIO 9'h000
`define HPMUX_RST_CAP 1'h0
// edges after reset release before the synced straps are valid
`define HPMUX_STRAP_SETTLE 2'h2
`endif

//--- rtl/hpmux_sync.v
`timescale 1ns/1ps
// two-stage synchroniser per bit
module hpmux_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // data
    input wire [W-1:0] asyncIn,
    output wire [W-1:0] syncOut
);
    reg [W-1:0] stage1_q;
    reg [W-1:0] stage2_q;

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1_q <= {W{1'b0}};
            stage2_q <= {W{1'b0}};
        end
        else
        begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
        end
    end

    assign syncOut = stage2_q;
endmodule

//--- rtl/hpmux_top.v
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "hpmux_map.vh"
module hpmux_top (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // register port
    input wire [3:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdData,
    // shared pins, three signals each
    input wire [8:0] pinIn,
    output reg [8:0] pinOut,
    output reg [8:0] pinOe,
    // green-low input pins
    input wire [4:0] greenLowInputs,
    // alternate pin select, active low
    input wire altPinSelect_n,
    // burst controller
    input wire burstDone,
    input wire transferDone,
    output wire burstGo,
    // bus slave
    input wire slaveWritePending,
    // rom loader
    input wire romChipSelect,
    input wire romClock,
    input wire romSerialOut,
    output wire romSerialIn,
    output wire romConfigEnable,
    output wire romModeActive,
    // serial interface
    input wire serClock,
    input wire serTxData,
    input wire serStrobe,
    output wire serRxData,
    output wire serialActive,
    // rgb capture
    output reg [5:0] rgbRed,
    output reg [5:0] rgbGreen,
    output wire rgbActive
);
    // synchronised pins
    wire [8:0] pinSync;
    wire [4:0] greenSync;
    wire altSelSync_n;

    hpmux_sync #(.W(15)) uSync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .asyncIn({altPinSelect_n, greenLowInputs, pinIn}),
        .syncOut({altSelSync_n, greenSync, pinSync})
    );

    // reset phase tracking and strap latches
    reg resetDone_q;
    reg [1:0] settle_q;
    reg strapRom_q;
    reg strapRgb_q;
    reg [2:0] mode_q;
    reg [8:0] gpioOut_q;
    reg [8:0] gpioOe_q;
    reg capRgb_q;

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            resetDone_q <= 1'b0;
            settle_q <= 2'h0;
            strapRom_q <= 1'b0;
            strapRgb_q <= 1'b0;
        end
        else if (!resetDone_q)
        begin
            // synchroniser is cleared by reset; wait until it holds pins
            if (settle_q == `HPMUX_STRAP_SETTLE)
            begin
                resetDone_q <= 1'b1;
                strapRom_q <= pinSync[`HPMUX_PIN_TD];
                strapRgb_q <= pinSync[`HPMUX_PIN_BG];
            end
            else
                settle_q <= settle_q + 2'h1;
        end
    end

    // register writes
    wire wrMode = regWr && (regAddr == `HPMUX_OFS_MODE) && resetDone_q;
    wire strapLoad = !resetDone_q && (settle_q == `HPMUX_STRAP_SETTLE);

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_q <= `HPMUX_RST_MODE;
            gpioOut_q <= `HPMUX_RST_GPIO;
            gpioOe_q <= `HPMUX_RST_GPIO;
            capRgb_q <= `HPMUX_RST_CAP;
        end
        else
        begin
            if (strapLoad)
            begin
                // straps preset the mode register
                if (pinSync[`HPMUX_PIN_TD])
                    mode_q[1:0] <= `HPMUX_MODE_ROM;
                mode_q[`HPMUX_MODE_RGB_BIT] <= pinSync[`HPMUX_PIN_BG];
                capRgb_q <= pinSync[`HPMUX_PIN_BG];
            end
            else if (wrMode)
                mode_q <= regWrData[2:0];
            if (regWr && regAddr == `HPMUX_OFS_GPIO_OUT)
                gpioOut_q <= regWrData[8:0];
            if (regWr && regAddr == `HPMUX_OFS_GPIO_OE)
                gpioOe_q <= regWrData[8:0];
            if (resetDone_q && regWr && regAddr == `HPMUX_OFS_CAPTURE)
                capRgb_q <= regWrData[`HPMUX_CAP_RGB_BIT];
        end
    end

    // mode decode
    wire [1:0] baseMode = mode_q[1:0];
    wire rgbReq = mode_q[`HPMUX_MODE_RGB_BIT];
    assign rgbActive = rgbReq && capRgb_q && !altSelSync_n;
    // rgb takes the shared pins first
    assign romModeActive = (baseMode == `HPMUX_MODE_ROM) && !rgbActive;
    assign serialActive = (baseMode == `HPMUX_MODE_SERIAL) &&
                          !rgbActive && !rgbReq;
    wire primaryActive = (baseMode == `HPMUX_MODE_PRIMARY) && !rgbActive;

    // is pin owned by rom or rgb use
    function isRomPin;
        input integer idx;
        begin
            isRomPin = (idx == `HPMUX_PIN_CFG) || (idx == `HPMUX_PIN_CS) ||
                       (idx == `HPMUX_PIN_CK) || (idx == `HPMUX_PIN_DO) ||
                       (idx == `HPMUX_PIN_DI);
        end
    endfunction

    function isRgbPin;
        input integer idx;
        begin
            isRgbPin = isRomPin(idx) || (idx == `HPMUX_PIN_BD) ||
                       (idx == `HPMUX_PIN_SW);
        end
    endfunction

    // pin drive per mode
    integer i;
    always @*
    begin
        pinOut = gpioOut_q;
        pinOe = gpioOe_q;
        for (i = 0; i < `HPMUX_NPINS; i = i + 1)
        begin
            if (rgbActive && isRgbPin(i))
            begin
                pinOut[i] = 1'b0;
                pinOe[i] = 1'b0;
            end
            else if (romModeActive && isRomPin(i))
            begin
                pinOut[i] = 1'b0;
                pinOe[i] = 1'b0;
            end
        end
        if (romModeActive)
        begin
            pinOut[`HPMUX_PIN_CS] = romChipSelect;
            pinOe[`HPMUX_PIN_CS] = 1'b1;
            pinOut[`HPMUX_PIN_CK] = romClock;
            pinOe[`HPMUX_PIN_CK] = 1'b1;
            pinOut[`HPMUX_PIN_DO] = romSerialOut;
            pinOe[`HPMUX_PIN_DO] = 1'b1;
        end
        if (serialActive)
        begin
            pinOut[`HPMUX_PIN_CK] = serClock;
            pinOe[`HPMUX_PIN_CK] = 1'b1;
            pinOut[`HPMUX_PIN_DO] = serTxData;
            pinOe[`HPMUX_PIN_DO] = 1'b1;
            pinOe[`HPMUX_PIN_DI] = 1'b0;
            pinOut[`HPMUX_PIN_SW] = serStrobe;
            pinOe[`HPMUX_PIN_SW] = 1'b1;
        end
        if (primaryActive)
        begin
            pinOut[`HPMUX_PIN_BD] = burstDone;
            pinOe[`HPMUX_PIN_BD] = 1'b1;
            pinOut[`HPMUX_PIN_TD] = transferDone;
            pinOe[`HPMUX_PIN_TD] = 1'b1;
            pinOe[`HPMUX_PIN_BG] = 1'b0;
            pinOut[`HPMUX_PIN_SW] = slaveWritePending;
            pinOe[`HPMUX_PIN_SW] = 1'b1;
        end
    end

    // routed inputs; burst-go permits when pin not owned
    assign burstGo = primaryActive ? pinSync[`HPMUX_PIN_BG] : 1'b1;
    assign romSerialIn = romModeActive & pinSync[`HPMUX_PIN_DI];
    assign romConfigEnable = romModeActive &
                             pinSync[`HPMUX_PIN_CFG];
    assign serRxData = serialActive & pinSync[`HPMUX_PIN_DI];

    // rgb data registered
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rgbRed <= 6'h00;
            rgbGreen <= 6'h00;
        end
        else if (rgbActive)
        begin
            rgbRed <= {pinSync[`HPMUX_PIN_CFG], pinSync[`HPMUX_PIN_DI],
                       pinSync[`HPMUX_PIN_CS], pinSync[`HPMUX_PIN_CK],
                       pinSync[`HPMUX_PIN_DO], pinSync[`HPMUX_PIN_BD]};
            rgbGreen <= {pinSync[`HPMUX_PIN_SW], greenSync};
        end
    end

    // read port; green-low pins only ever read
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            regRdData <= 32'h0000_0000;
        else if (regRd)
        begin
            case (regAddr)
                `HPMUX_OFS_MODE: regRdData <= {29'h0000_0000, mode_q};
                `HPMUX_OFS_GPIO_OUT: regRdData <= {23'h00_0000, gpioOut_q};
                `HPMUX_OFS_GPIO_OE: regRdData <= {23'h00_0000, gpioOe_q};
                `HPMUX_OFS_GPIO_IN: regRdData <= {18'h0_0000, greenSync,
                                                  pinSync};
                `HPMUX_OFS_CAPTURE: regRdData <= {31'h0000_0000, capRgb_q};
                `HPMUX_OFS_STATUS: regRdData <= {26'h000_0000, strapRgb_q,
                                                 strapRom_q, rgbActive,
                                                 serialActive, romModeActive,
                                                 primaryActive};
                default: regRdData <= 32'h0000_0000;
            endcase
        end
        else
            regRdData <= 32'h0000_0000;
    end
endmodule

//--- tb/hpmux_properties.sv
`timescale 1ns/1ps
module hpmux_properties (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // watched ports
    input wire regRd,
    input wire [31:0] regRdData,
    input wire [8:0] pinIn,
    input wire [8:0] pinOut,
    input wire [8:0] pinOe,
    input wire [4:0] greenLowInputs,
    input wire serClock,
    input wire serTxData,
    input wire serStrobe,
    input wire romModeActive,
    input wire serialActive,
    input wire rgbActive,
    input wire [5:0] rgbRed,
    input wire [5:0] rgbGreen
);
    wire [5:0] redIn = {pinIn[0], pinIn[4], pinIn[1], pinIn[2], pinIn[3],
        pinIn[5]};
    wire [5:0] grnIn = {pinIn[8], greenLowInputs};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    chk_read_idle: assert property (!$past(regRd) |-> regRdData == 0)
        else $error("read data not idle");
    chk_serial_excl: assert property (serialActive |->
        !romModeActive && !rgbActive) else $error("serial overlaps");
    chk_serial_data: assert property (serialActive |->
        pinOe[3:2] == 2'h3 && pinOut[3:2] == {serTxData, serClock})
        else $error("serial pins wrong");
    chk_serial_strobe: assert property (serialActive |->
        pinOe[8] && pinOut[8] == serStrobe) else $error("strobe wrong");
    chk_rgb_inputs: assert property (rgbActive |->
        (pinOe & 9'h13f) == 9'h000) else $error("rgb pin driven");
    chk_rgb_data: assert property ($past(rgbActive) && $past(nrst, 3) |->
        rgbRed == $past(redIn, 3) && rgbGreen == $past(grnIn, 3))
        else $error("rgb data wrong");
    chk_rgb_hold: assert property (!rgbActive |=> $stable(rgbRed))
        else $error("rgb data moved");
    chk_rom_pins: assert property (romModeActive |->
        pinOe[4:0] == 5'h0e) else $error("rom pins wrong");
    chk_rom_rgb: assert property (rgbActive |-> !romModeActive)
        else $error("rom beside rgb");
    cover property (serialActive);
    cover property (rgbActive);
    cover property (romModeActive);
endmodule
bind hpmux_top hpmux_properties u_chk (.*);

//--- tb/hpmux_board.sv
`timescale 1ns/1ps
module hpmux_board (
    // design side
    input wire [8:0] pinOut,
    input wire [8:0] pinOe,
    // board side
    input wire [8:0] ext,
    input wire pullRom,
    input wire pullRgb,
    output wire [8:0] pinIn
);
    // released pins: fitted pull-ups, else board drive
    wire [8:0] rel = {ext[8], pullRgb | ext[7],
        pullRom | ext[6], ext[5:0]};
    assign pinIn = (pinOe & pinOut) | (~pinOe & rel);
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("mismatch t=%0t %h %h", $time, a, b); end end
module tb;
    reg ref_clk = 0, nrst = 0, regWr = 0, regRd = 0, altPinSelect_n = 0;
    reg pullRom = 0, pullRgb = 0;
    reg [3:0] regAddr = 4'h0;
    reg [31:0] regWrData = 32'h0000_0000, seed = 32'h0000_74f4, t, d, u;
    reg [8:0] ext = 9'h000, lv = 9'h000;
    reg [4:0] greenLowInputs = 5'h00;
    wire [31:0] regRdData;
    wire [8:0] pinIn, pinOut, pinOe;
    wire [5:0] rgbRed, rgbGreen;
    wire burstDone, transferDone, slaveWritePending, romChipSelect, romClock;
    wire romSerialOut, serClock, serTxData, serStrobe, burstGo, romSerialIn;
    wire romConfigEnable, romModeActive, serRxData, serialActive, rgbActive;
    int num_errors = 0, compares = 0, i;
    assign {burstDone, transferDone, slaveWritePending, romChipSelect,
        romClock, romSerialOut, serClock, serTxData, serStrobe} = lv;
    hpmux_top u_hpmux_top (.*);
    hpmux_board u_hpmux_board (.*);
    initial forever #5 ref_clk = ~ref_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    always @(posedge ref_clk)
    begin
        u = rnd();
        lv <= u[8:0];
    end
    task wr(input [3:0] a, input [31:0] v);
        @(posedge ref_clk);
        regWr <= 1;
        regAddr <= a;
        regWrData <= v;
        @(posedge ref_clk);
        regWr <= 0;
        #1;
    endtask
    task rd(input [3:0] a);
        @(posedge ref_clk);
        regRd <= 1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 0;
        #1 d = regRdData;
    endtask
    task rst(input r, input g);
        @(posedge ref_clk);
        t = rnd();
        ext <= t[8:0] & 9'h13f;
        greenLowInputs <= t[13:9];
        {pullRom, pullRgb, nrst} <= {r, g, 1'b0};
        repeat (20) @(posedge ref_clk);
        nrst <= 1;
        repeat (4) @(posedge ref_clk);
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #900000 num_errors++;
        print_verdict;
    end
    initial
    begin
        for (i = 3; i >= 0; i--)
        begin
            rst(i[0], i[1]);
            #1 if (i == 0) `CHK(pinOe, 9'h000)
            rd(4'h5);
            `CHK(d[5:0], {i[1], i[0], i[1], 1'b0, i[0] & ~i[1], 1'b0})
            if (i[1])
            begin
                `CHK(rgbRed, {ext[0], ext[4], ext[1], ext[2], ext[3], ext[5]})
                `CHK(rgbGreen, {ext[8], greenLowInputs})
                altPinSelect_n <= 1;
                rd(4'h5);
                rd(4'h5);
                `CHK(d[3], 1'b0)
                altPinSelect_n <= 0;
            end
        end
        rd(4'h3);
        `CHK(d[13:0], {greenLowInputs, ext})
        t = rnd();
        wr(4'h2, t);
        wr(4'h1, ~t);
        `CHK(pinOe, t[8:0])
        `CHK(pinOut & t[8:0], ~t[8:0] & t[8:0])
        wr(4'h2, 32'h0000_0000);
        wr(4'h0, 32'h0000_0001);
        `CHK(pinOe[8:5], 4'hb)
        `CHK({pinOut[8], pinOut[6:5]}, {slaveWritePending, transferDone, burstDone})
        `CHK(burstGo, ext[7])
        wr(4'h0, 32'h0000_0002);
        `CHK(serialActive, 1'b1)
        `CHK(serRxData, ext[4])
        wr(4'h0, 32'h0000_0006);
        `CHK(serialActive, 1'b0)
        wr(4'h0, 32'h0000_0003);
        `CHK(romModeActive, 1'b1)
        wr(4'h4, 32'h0000_0001);
        wr(4'h0, 32'h0000_0007);
        `CHK(rgbActive, 1'b1)
        rd(4'hf);
        `CHK(d, 32'h0000_0000)
        print_verdict;
    end
endmodule
